// ===== sram_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_map.svh"
module sram_ctrl
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // user request
   input  wire logic                       req_valid,
   input  wire sram_ctrl_pkg::cmd_t        req_cmd,
   input  wire sram_ctrl_pkg::word_addr_t  req_addr,
   input  wire logic                       req_wdata,
   output logic                            req_ready,
   // user answer
   output logic                            rsp_valid,
   output logic                            rsp_rdata,
   // supply management
   input  wire logic                       retain_req,
   output logic                            retain_ok,
   // memory pins
   output sram_ctrl_pkg::word_addr_t       word_address_lines,
   output logic                            select_n,
   output logic                            write_strobe_n,
   output logic                            data_in,
   input  wire logic                       data_out
);

   function automatic logic [7:0] cyc8(input logic [31:0] c);
      cyc8 = c[7:0];
   endfunction

   sram_ctrl_pkg::state_t state_reg;
   logic                  is_write_reg;
   logic                  tmr_load;
   logic [7:0]            tmr_count;
   logic                  tmr_done;

   cycle_timer i_cycle_timer
   (
      .clk   (clk),
      .rst   (rst),
      .load  (tmr_load),
      .count (tmr_count),
      .done  (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // timer loads on each state change except the returns to ST_IDLE
   always_comb
   begin
      tmr_load  = 1'b0;
      tmr_count = 8'h01;
      case (state_reg)
         sram_ctrl_pkg::ST_IDLE:
         begin
            if (retain_req)
            begin
               tmr_load  = 1'b1;
               tmr_count = cyc8(`RETENTION_CYC);
            end
            else if (req_valid)
            begin
               tmr_load  = 1'b1;
               tmr_count = cyc8(`SETUP_CYC);
            end
         end
         sram_ctrl_pkg::ST_SETUP:
         begin
            if (tmr_done)
            begin
               tmr_load  = 1'b1;
               tmr_count = is_write_reg ? cyc8(`WRITE_PULSE_CYC)
                                        : cyc8(`READ_WAIT_CYC);
            end
         end
         sram_ctrl_pkg::ST_READ, sram_ctrl_pkg::ST_WRITE:
         begin
            if (tmr_done)
            begin
               tmr_load  = 1'b1;
               tmr_count = cyc8(`HOLD_CYC);
            end
         end
         sram_ctrl_pkg::ST_HOLD:
         begin
            if (tmr_done)
            begin
               tmr_load  = 1'b1;
               tmr_count = is_write_reg ? cyc8(`FLOAT_CYC)
                                        : cyc8(`FLOAT_CYC);
            end
         end
         sram_ctrl_pkg::ST_RETAIN:
         begin
            if (!retain_req)
            begin
               tmr_load  = 1'b1;
               tmr_count = cyc8(`READ_CYCLE_CYC);
            end
         end
         default:
         begin
            tmr_load  = 1'b0;
            tmr_count = 8'h01;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencing
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_reg <= sram_ctrl_pkg::ST_IDLE;
      else
         case (state_reg)
            sram_ctrl_pkg::ST_IDLE:
               if (retain_req)
                  state_reg <= sram_ctrl_pkg::ST_RETAIN;
               else if (req_valid)
                  state_reg <= sram_ctrl_pkg::ST_SETUP;
            sram_ctrl_pkg::ST_SETUP:
               if (tmr_done)
                  state_reg <= is_write_reg ? sram_ctrl_pkg::ST_WRITE
                                            : sram_ctrl_pkg::ST_READ;
            sram_ctrl_pkg::ST_READ, sram_ctrl_pkg::ST_WRITE:
               if (tmr_done)
                  state_reg <= sram_ctrl_pkg::ST_HOLD;
            sram_ctrl_pkg::ST_HOLD:
               if (tmr_done)
                  state_reg <= sram_ctrl_pkg::ST_RECOVER;
            sram_ctrl_pkg::ST_RECOVER:
               if (tmr_done)
                  state_reg <= sram_ctrl_pkg::ST_IDLE;
            sram_ctrl_pkg::ST_RETAIN:
               if (!retain_req)
                  state_reg <= sram_ctrl_pkg::ST_RESUME;
            sram_ctrl_pkg::ST_RESUME:
               if (tmr_done)
                  state_reg <= sram_ctrl_pkg::ST_IDLE;
            default:
               state_reg <= sram_ctrl_pkg::ST_IDLE;
         endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // address and write data capture
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         word_address_lines <= `ADDR_RESET;
         data_in            <= 1'b0;
         is_write_reg       <= 1'b0;
      end
      // address moves only while both strobes are high
      // and stays put until the next request
      else if (state_reg == sram_ctrl_pkg::ST_IDLE && req_valid && !retain_req)
      begin
         word_address_lines <= req_addr;
         data_in            <= req_wdata;
         is_write_reg       <= (req_cmd == sram_ctrl_pkg::CMD_WRITE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control pins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         select_n       <= 1'b1;
         write_strobe_n <= 1'b1;
      end
      else
         case (state_reg)
            sram_ctrl_pkg::ST_SETUP:
               if (tmr_done)
               begin
                  // write starts as both go low together
                  select_n       <= 1'b0;
                  write_strobe_n <= !is_write_reg;
               end
            sram_ctrl_pkg::ST_READ, sram_ctrl_pkg::ST_WRITE:
               if (tmr_done)
               begin
                  // select rises to end the cycle, together with the write strobe in a write
                  // deselect lets the memory power down
                  select_n       <= 1'b1;
                  write_strobe_n <= 1'b1;
               end
            default:
            begin
               select_n       <= 1'b1;
               write_strobe_n <= 1'b1;
            end
         endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // user handshake and read data
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 1'b0;
         retain_ok <= 1'b0;
      end
      else
      begin
         req_ready <= (state_reg == sram_ctrl_pkg::ST_IDLE) && !req_valid
                      && !retain_req;
         rsp_valid <= 1'b0;
         // sample only after the full access time
         // early data may be junk, so never earlier
         if (state_reg == sram_ctrl_pkg::ST_READ && tmr_done)
         begin
            rsp_valid <= 1'b1;
            rsp_rdata <= data_out;
         end
         else if (state_reg == sram_ctrl_pkg::ST_WRITE && tmr_done)
            rsp_valid <= 1'b1;
         retain_ok <= (state_reg == sram_ctrl_pkg::ST_RETAIN);
      end
   end

endmodule
`default_nettype wire

// ===== sram_ctrl_map.svh
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH

// times in picoseconds: 4 ns clock
`define CLK_PERIOD_PS             32'h0000_0fa0
// speed grade 25 ns: 25, 20 and 10 ns below
`define ADDRESS_ACCESS_TIME_PS    32'h0000_61a8
`define SELECT_ACCESS_TIME_PS     32'h0000_61a8
`define READ_CYCLE_TIME_PS        32'h0000_61a8
`define WRITE_CYCLE_TIME_PS       32'h0000_61a8
`define WRITE_PULSE_TIME_PS       32'h0000_4e20
`define DATA_SETUP_TIME_PS        32'h0000_4e20
`define STROBE_TO_FLOAT_TIME_PS   32'h0000_2710
`define WRITE_DATA_HOLD_TIME_PS   32'h0000_0000
`define ADDRESS_SETUP_TIME_PS     32'h0000_0000
`define DESELECT_BEFORE_RET_PS    32'h0000_0000

// least times round up, never below one cycle
`define CYC_UP(t) (((t) + `CLK_PERIOD_PS - 32'h0000_0001) / `CLK_PERIOD_PS)
`define CYC_MIN1(t) ((`CYC_UP(t) == 32'h0000_0000) ? 32'h0000_0001 : `CYC_UP(t))

`define READ_WAIT_CYC    `CYC_MIN1(`ADDRESS_ACCESS_TIME_PS)
`define READ_CYCLE_CYC   `CYC_MIN1(`READ_CYCLE_TIME_PS)
`define WRITE_PULSE_CYC  `CYC_MIN1(`WRITE_PULSE_TIME_PS)
`define WRITE_CYCLE_CYC  `CYC_MIN1(`WRITE_CYCLE_TIME_PS)
`define FLOAT_CYC        `CYC_MIN1(`STROBE_TO_FLOAT_TIME_PS)
`define HOLD_CYC         `CYC_MIN1(`WRITE_DATA_HOLD_TIME_PS)
`define SETUP_CYC        `CYC_MIN1(`ADDRESS_SETUP_TIME_PS)
`define RETENTION_CYC    `CYC_MIN1(`DESELECT_BEFORE_RET_PS)

`define ADDR_RESET       16'h0000

`endif

// ===== sram_ctrl_pkg.sv
package sram_ctrl_pkg;
   typedef logic [15:0] word_addr_t;
   typedef enum logic [1:0] {
      CMD_READ,
      CMD_WRITE
   } cmd_t;
   typedef enum {
      ST_IDLE,
      ST_SETUP,
      ST_READ,
      ST_WRITE,
      ST_HOLD,
      ST_RECOVER,
      ST_RETAIN,
      ST_RESUME
   } state_t;
endpackage

// ===== cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // load and status
   input  wire logic        load,
   input  wire logic [7:0]  count,
   output logic             done
);

   logic [7:0] remain_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         remain_reg <= 8'h00;
      else if (load)
         remain_reg <= count;
      else if (remain_reg != 8'h00)
         remain_reg <= remain_reg - 8'h01;
   end

   // done in the last cycle of the loaded count, and while stopped at zero without a load
   assign done = (remain_reg == 8'h01) || (remain_reg == 8'h00 && !load);

endmodule
`default_nettype wire

// ===== sram_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_monitor
(
   // clock and reset
   input wire logic                      clk,
   input wire logic                      rst,
   // answer and pins
   input wire logic                      rsp_valid,
   input wire logic                      retain_ok,
   input wire sram_ctrl_pkg::word_addr_t word_address_lines,
   input wire logic                      select_n,
   input wire logic                      write_strobe_n,
   input wire logic                      data_in
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   //////////////////////////////////////////////////////////////////////
   a_addr_move_idle: assert property (
      !$stable(word_address_lines) |-> select_n || write_strobe_n)
      else $error("address moved during a write");
   a_wr_addr_hold: assert property (
      !select_n && !write_strobe_n |=> $stable(word_address_lines))
      else $error("address moved inside write");
   a_wr_data_hold: assert property (
      !select_n && !write_strobe_n |=> $stable(data_in))
      else $error("write data moved inside write");
   a_wr_pulse_len: assert property (
      $fell(write_strobe_n) |-> (!select_n && !write_strobe_n) [*5])
      else $error("write pulse too short");
   a_wr_end_edge: assert property (
      $rose(write_strobe_n) |-> $rose(select_n))
      else $error("write end not on a joint rise");
   a_strobe_sel: assert property (
      !write_strobe_n |-> !select_n)
      else $error("strobe low while deselected");
   a_rd_access: assert property (
      $fell(select_n) && write_strobe_n |-> (!select_n) [*7])
      else $error("read shorter than access time");
   a_rsp_at_end: assert property (
      rsp_valid |-> $rose(select_n))
      else $error("answer not at end of access");
   a_retain_desel: assert property (
      retain_ok |-> select_n && write_strobe_n)
      else $error("retention while selected");
   c_write: cover property ($fell(write_strobe_n));
   c_read: cover property ($fell(select_n) && write_strobe_n);
   c_retain: cover property ($rose(retain_ok));
endmodule
bind sram_ctrl sram_ctrl_monitor i_sram_ctrl_monitor (.clk, .rst,
   .rsp_valid, .retain_ok, .word_address_lines, .select_n,
   .write_strobe_n, .data_in);
`default_nettype wire

// ===== sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_model
#(
   parameter int ACC_CYC = 6
)
(
   // clock of the bench
   input wire logic                      clk,
   // memory pins
   input wire sram_ctrl_pkg::word_addr_t word_address_lines,
   input wire logic                      select_n,
   input wire logic                      write_strobe_n,
   input wire logic                      data_in,
   output logic                          data_out
);
   logic                      mem [0:65535];
   logic [3:0]                cnt = 4'h0;
   logic                      junk = 1'b0;
   sram_ctrl_pkg::word_addr_t addr_q;
   //////////////////////////////////////////////////////////////////////
   // contents kept in standby
   always @(posedge clk)
   begin
      junk <= ~junk;
      addr_q <= word_address_lines;
      if (select_n || word_address_lines !== addr_q)
         cnt <= 4'h0;
      else if (cnt != 4'hf)
         cnt <= cnt + 4'h1;
      if (!select_n && !write_strobe_n)
         mem[word_address_lines] <= data_in;
   end
   assign data_out = (!select_n && write_strobe_n && cnt >= ACC_CYC)
                     ? mem[word_address_lines] : junk;
endmodule
`default_nettype wire

// ===== sram_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_tb_top;
   logic                      clk, rst, req_valid, req_wdata, req_ready;
   logic                      rsp_valid, rsp_rdata, retain_req, retain_ok;
   logic                      select_n, write_strobe_n, data_in, data_out;
   sram_ctrl_pkg::cmd_t       req_cmd;
   sram_ctrl_pkg::word_addr_t req_addr, word_address_lines;
   int                        errors = 0;
   int                        n_compared = 0;
   logic                      rd;
   sram_ctrl i_sram_ctrl (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .retain_req(retain_req), .retain_ok(retain_ok),
      .word_address_lines(word_address_lines), .select_n(select_n),
      .write_strobe_n(write_strobe_n), .data_in(data_in),
      .data_out(data_out));
   sram_model i_sram_model (.clk(clk),
      .word_address_lines(word_address_lines), .select_n(select_n),
      .write_strobe_n(write_strobe_n), .data_in(data_in),
      .data_out(data_out));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      if (errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one access, request held until the answer pulse
   task automatic access(sram_ctrl_pkg::cmd_t c, logic [15:0] a, logic d);
      req_cmd = c;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      for (int i = 0; i < 40 && rsp_valid !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      if (rsp_valid !== 1'b1)
      begin
         errors++;
         test_done();
      end
      rd = rsp_rdata;
      chk("ready while busy", {15'h0000, req_ready}, 16'h0000);
      req_valid = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic t_fill_and_check;
      logic [15:0] a [4] = '{16'h0000, 16'hffff, 16'h1234, 16'h8001};
      for (int i = 0; i < 4; i++)
         access(sram_ctrl_pkg::CMD_WRITE, a[i], i[0]);
      for (int i = 0; i < 4; i++)
      begin
         access(sram_ctrl_pkg::CMD_READ, a[i], 1'b0);
         chk("read back", {15'h0000, rd}, {15'h0000, i[0]});
      end
   endtask
   task automatic t_overwrite;
      for (int i = 0; i < 2; i++)
      begin
         access(sram_ctrl_pkg::CMD_WRITE, 16'h00ff, ~i[0]);
         access(sram_ctrl_pkg::CMD_READ, 16'h00ff, i[0]);
         chk("overwrite", {15'h0000, rd}, {15'h0000, ~i[0]});
      end
   endtask
   task automatic t_retain;
      logic seen_rsp;
      seen_rsp = 1'b0;
      retain_req = 1'b1;
      for (int i = 0; i < 40 && retain_ok !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      chk("retain ok", {15'h0000, retain_ok}, 16'h0001);
      if (retain_ok !== 1'b1)
         test_done();
      req_cmd = sram_ctrl_pkg::CMD_READ;
      req_addr = 16'hffff;
      req_valid = 1'b1;
      repeat (10)
      begin
         @(posedge clk);
         #1;
         seen_rsp = seen_rsp | rsp_valid;
      end
      chk("select in retention", {15'h0000, select_n}, 16'h0001);
      chk("refused in retention", {15'h0000, seen_rsp}, 16'h0000);
      chk("ready in retention", {15'h0000, req_ready}, 16'h0000);
      retain_req = 1'b0;
      // a read cycle time, 7 clocks, must pass before any select
      seen_rsp = 1'b0;
      repeat (7)
      begin
         @(posedge clk);
         #1;
         seen_rsp = seen_rsp | ~select_n;
      end
      chk("recovery wait", {15'h0000, seen_rsp}, 16'h0000);
      chk("retain ok cleared", {15'h0000, retain_ok}, 16'h0000);
      access(sram_ctrl_pkg::CMD_READ, 16'hffff, 1'b0);
      chk("kept in retention", {15'h0000, rd}, 16'h0001);
   endtask
   initial
   begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_cmd = sram_ctrl_pkg::CMD_READ;
      req_addr = 16'h0000;
      req_wdata = 1'b0;
      retain_req = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("pins in reset", {14'h0000, select_n, write_strobe_n}, 16'h0003);
      rst = 1'b0;
      @(posedge clk);
      #1;
      chk("ready when idle", {15'h0000, req_ready}, 16'h0001);
      t_fill_and_check();
      t_overwrite();
      t_retain();
      test_done();
   end
endmodule
`default_nettype wire
